// ---- logic/hsfp_core.sv ----
/*
 * Host supervision and fault pins of a battery pack monitor: APB
 * registers, host-silence watchdog with pulsed attention output,
 * override clearing, switch gating, fault indicator pins and the
 * charger monitor roles. Instantiates the serial link monitor.
 * Assumes analog comparators deliver fault levels on pclk; pins from
 * outside pass two flops first.
 */
// Overview of operation
// - Address lsb follows the select pin
// - Separate data in and out pins
// - Attention output only with override set
// - Silence timeout asserts attention, kills switches
// - After timeout pulse attention 1us each second
// - Switches blocked until a transaction occurs
// - Resume clears overrides except balance ownership
// - Switches allowed again after resume
// - Pack fault on cell overvoltage lockout
// - Cell fail, open wire faults when enabled
// - Pack fault follows condition, never latched
// - Forced-off input kills all switches
// - Shutdown output on listed faults
// - Shutdown also when switches off asleep
// - End-of-charge output above its threshold
// - Charger monitor: recovery and sleep wake
// - No charger clears charge overcurrent flag
`timescale 1ns/1ps
`include "hsfp_defs.svh"

module hsfp_core import hsfp_pkg::*; #(
    parameter int unsigned SEC_CYCLES   = `HSFP_SEC_CYC,
    parameter int unsigned PULSE_CYCLES = `HSFP_PULSE_CYC,
    parameter int unsigned CELLS        = 8
) (
    // Clock, reset, enable
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             ce,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Serial link pins
    input  wire logic             address_select_pin,
    input  wire logic             serial_clock_pin,
    input  wire logic             serial_data_input_pin,
    output logic                  serial_data_output_pin,
    output logic                  serial_data_output_oe_n,
    // Control pins
    input  wire logic             force_switches_off_in,
    input  wire logic             charger_monitor_in,
    // Fault levels from comparators, pclk domain
    input  wire logic             cell_overvoltage_lockout,
    input  wire logic             cell_fail,
    input  wire logic             open_wire_fail,
    input  wire logic             cell_undervoltage,
    input  wire logic             discharge_overcurrent,
    input  wire logic             discharge_short_circuit,
    input  wire logic             discharge_overheat,
    input  wire logic             discharge_too_cold,
    input  wire logic             die_overheat,
    input  wire logic             charge_overcurrent,
    input  wire logic             charge_complete_threshold,
    input  wire logic             sleep_mode,
    // Indicator pins
    output logic                  attention_n,
    output logic                  pack_fault_out,
    output logic                  shutdown_indicator_n,
    output logic                  shutdown_oe_n,
    output logic                  charge_complete_n,
    output logic                  charge_complete_oe_n,
    // Switch drives and status
    output logic [CELLS-1:0]      balance_gate_output,
    output logic [1:0]            power_switch_on,
    output logic                  scan_enable,
    output logic                  wake_request,
    output logic                  charge_overcurrent_flag,
    output logic                  irq
);
    // Registers
    logic [8:0]             override_bits;
    logic [9:0]             config_bits;
    logic [`HSFP_EV_WIDTH-1:0] irq_stat;
    logic [`HSFP_EV_WIDTH-1:0] irq_mask;
    logic [CELLS+1:0]       switch_req;
    // Synchronisers and strap
    logic [1:0]             off_sync;
    logic [1:0]             chg_sync;
    logic [1:0]             addr_sync;
    // Watchdog
    hsfp_wd_state_t         wd_state;
    hsfp_wd_state_t         next_wd_state;
    logic [31:0]            sec_cnt;
    logic [4:0]             wd_secs;
    logic [31:0]            pulse_cnt;
    logic                   fault_q;
    logic                   xfer_done;

    // Serial link monitor
    hsfp_link_mon u_link (
        .pclk                   (pclk),
        .presetn                (presetn),
        .ce                     (ce),
        .serial_clock_pin       (serial_clock_pin),
        .serial_data_input_pin  (serial_data_input_pin),
        .addr_lsb               (addr_sync[1]),
        .serial_data_output_pin (serial_data_output_pin),
        .serial_data_output_oe_n(serial_data_output_oe_n),
        .xfer_done              (xfer_done)
    );

    // Two-flop synchronisers for pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            off_sync  <= 2'h0;
            chg_sync  <= 2'h0;
            addr_sync <= 2'h0;
        end else if (ce) begin
            off_sync  <= {off_sync[0], force_switches_off_in};
            chg_sync  <= {chg_sync[0], charger_monitor_in};
            addr_sync <= {addr_sync[0], address_select_pin};
        end
    end

    // APB decode, single wait-free access phase
    wire logic acc        = psel & penable;
    wire logic wr         = acc & pwrite & ce;
    wire logic hit_ovr    = paddr == `HSFP_OFS_OVERRIDE;
    wire logic hit_cfg    = paddr == `HSFP_OFS_CONFIG;
    wire logic hit_state  = paddr == `HSFP_OFS_STATE;
    wire logic hit_istat  = paddr == `HSFP_OFS_IRQ_STAT;
    wire logic hit_imask  = paddr == `HSFP_OFS_IRQ_MASK;
    wire logic hit_switch = paddr == `HSFP_OFS_SWITCH;
    wire logic mapped     = hit_ovr | hit_cfg | hit_state | hit_istat |
                            hit_imask | hit_switch;
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;

    // Override and watchdog decodes
    wire logic [4:0] wd_cfg  = config_bits[`HSFP_CFG_WD_MSB:`HSFP_CFG_WD_LSB];
    wire logic any_override  = |override_bits[`HSFP_OVR_POWER:`HSFP_OVR_SCAN];
    wire logic timed_out     = wd_state == HSFP_WD_ALARM;
    wire logic sec_tick      = sec_cnt == SEC_CYCLES - 1;
    wire logic wd_expire     = sec_tick & (wd_secs == wd_cfg - 5'h1);
    wire logic pulse_on      = timed_out & (pulse_cnt < PULSE_CYCLES);
    wire logic resume        = timed_out & xfer_done;

    // Watchdog next state
    always_comb begin
        next_wd_state = wd_state;
        unique case (wd_state)
            HSFP_WD_IDLE:
                if (any_override && wd_cfg != 5'h0)
                    next_wd_state = HSFP_WD_WATCH;
            HSFP_WD_WATCH:
                if (!any_override || wd_cfg == 5'h0)
                    next_wd_state = HSFP_WD_IDLE;
                else if (wd_expire && !xfer_done)
                    next_wd_state = HSFP_WD_ALARM;
            HSFP_WD_ALARM:
                if (xfer_done)
                    next_wd_state = HSFP_WD_IDLE;
            default:
                next_wd_state = HSFP_WD_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wd_state <= HSFP_WD_IDLE;
        else if (ce)
            wd_state <= next_wd_state;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_cnt <= 32'h0;
            wd_secs <= 5'h0;
        end else if (ce) begin
            if (xfer_done || wd_state == HSFP_WD_IDLE) begin
                sec_cnt <= 32'h0;
                wd_secs <= 5'h0;
            end else begin
                sec_cnt <= sec_tick ? 32'h0 : sec_cnt + 32'h1;
                if (sec_tick && !timed_out)
                    wd_secs <= wd_secs + 5'h1;
            end
        end
    end

    // one short pulse per second in alarm
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pulse_cnt <= 32'h0;
        else if (ce) begin
            if (!timed_out || sec_tick)
                pulse_cnt <= 32'h0;
            else if (pulse_cnt < PULSE_CYCLES)
                pulse_cnt <= pulse_cnt + 32'h1;
        end
    end

    // attention only with an override set
    assign attention_n = ~(any_override & pulse_on);

    // Override register; hardware clear on resume wins over writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            override_bits <= `HSFP_OVR_RESET;
        else if (ce) begin
            if (resume) begin
                override_bits <= override_bits &
                                 (9'h001 << `HSFP_OVR_BALANCE);
            end else if (wr && hit_ovr)
                override_bits <= pwdata[8:0];
        end
    end

    // Configuration and switch requests
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_bits <= `HSFP_CFG_RESET;
            switch_req  <= '0;
            irq_mask    <= '0;
        end else if (ce && wr) begin
            if (hit_cfg)
                config_bits <= pwdata[9:0];
            if (hit_switch)
                switch_req <= pwdata[CELLS+1:0];
            if (hit_imask)
                irq_mask <= pwdata[`HSFP_EV_WIDTH-1:0];
        end
    end

    wire logic switch_block = timed_out | off_sync[1];
    genvar gi;
    generate
        for (gi = 0; gi < CELLS; gi++) begin : g_bal
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    balance_gate_output[gi] <= 1'b0;
                else if (ce)
                    balance_gate_output[gi] <= switch_req[gi] &
                                               ~switch_block;
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            power_switch_on <= 2'h0;
        else if (ce)
            power_switch_on <= switch_req[CELLS+1:CELLS] &
                               {2{~switch_block & ~charge_overcurrent_flag}};
    end

    // Scans pause in alarm and restart with the next transaction
    assign scan_enable = ~timed_out;

    // optional cell fail and open wire
    assign pack_fault_out = cell_overvoltage_lockout |
                            (cell_fail & config_bits[`HSFP_CFG_CELLF]) |
                            (open_wire_fail & config_bits[`HSFP_CFG_OPENW]);

    wire logic sd_assert = cell_undervoltage | discharge_overcurrent |
                           discharge_short_circuit | discharge_overheat |
                           discharge_too_cold | die_overheat |
                           charge_overcurrent_flag |
                           (sleep_mode & ~|power_switch_on);
    assign shutdown_indicator_n = 1'b0;
    assign shutdown_oe_n        = ~sd_assert;

    assign charge_complete_n    = 1'b0;
    assign charge_complete_oe_n = ~charge_complete_threshold;

    // charger wakes the device from sleep
    assign wake_request = sleep_mode & chg_sync[1];

    // automatic recovery clears flag, set wins
    wire logic coc_auto_clr = charge_overcurrent_flag & ~chg_sync[1] &
        ~override_bits[`HSFP_OVR_CHG_REC] & ~charge_overcurrent;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            charge_overcurrent_flag <= 1'b0;
        else if (ce)
            charge_overcurrent_flag <= charge_overcurrent |
                (charge_overcurrent_flag & ~coc_auto_clr);
    end

    // Sticky events, write one to clear, new event beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            fault_q <= 1'b0;
        else if (ce)
            fault_q <= pack_fault_out;
    end
    wire logic [`HSFP_EV_WIDTH-1:0] ev = {coc_auto_clr,
        pack_fault_out & ~fault_q, resume,
        (wd_state == HSFP_WD_WATCH) & (next_wd_state == HSFP_WD_ALARM)};
    wire logic [`HSFP_EV_WIDTH-1:0] w1c = (wr && hit_istat) ?
        pwdata[`HSFP_EV_WIDTH-1:0] : '0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq_stat <= '0;
        else if (ce)
            irq_stat <= ev | (irq_stat & ~w1c);
    end
    assign irq = |(irq_stat & irq_mask);

    // Read data mux, registered
    wire logic [31:0] state_word = {22'h0, addr_sync[1], chg_sync[1],
        off_sync[1], charge_overcurrent_flag, pack_fault_out, sd_assert,
        wd_state, timed_out};
    wire logic [31:0] rd_mux =
        hit_ovr    ? {23'h0, override_bits} :
        hit_cfg    ? {22'h0, config_bits} :
        hit_state  ? state_word :
        hit_istat  ? {28'h0, irq_stat} :
        hit_imask  ? {28'h0, irq_mask} :
        hit_switch ? {{(30-CELLS){1'b0}}, switch_req} : 32'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0;
        else if (ce && psel && !penable && !pwrite)
            prdata <= rd_mux;
    end

    // Checks
    a_att_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !any_override |-> attention_n)
        else $error("attention active without override");
    a_wd_expire: assert property (@(posedge pclk) disable iff (!presetn)
        ce && wd_state == HSFP_WD_WATCH && wd_expire && !xfer_done
        && any_override |=> timed_out && !attention_n)
        else $error("watchdog expiry not signalled");
    a_pulse_width: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(attention_n) |-> !attention_n [*2])
        else $error("attention pulse too short");
    a_block_sw: assert property (@(posedge pclk) disable iff (!presetn)
        timed_out ##1 timed_out |-> balance_gate_output == '0
        && power_switch_on == 2'h0)
        else $error("switch on during alarm");
    a_resume_clr: assert property (@(posedge pclk) disable iff (!presetn)
        resume && ce |=> override_bits[`HSFP_OVR_POWER] == 1'b0
        && override_bits[`HSFP_OVR_NV_EN] == 1'b0
        && override_bits[`HSFP_OVR_BALANCE] ==
           $past(override_bits[`HSFP_OVR_BALANCE]))
        else $error("override clear on resume wrong");
    a_release_sw: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !switch_block && switch_req[0] |=> balance_gate_output[0])
        else $error("balance output not released");
    a_fault_pin: assert property (@(posedge pclk) disable iff (!presetn)
        pack_fault_out == (cell_overvoltage_lockout ||
        (cell_fail && config_bits[`HSFP_CFG_CELLF]) ||
        (open_wire_fail && config_bits[`HSFP_CFG_OPENW])))
        else $error("pack fault mismatch");
    a_forced_off: assert property (@(posedge pclk) disable iff (!presetn)
        ce && off_sync[1] |=> power_switch_on == 2'h0)
        else $error("forced off ignored");
    a_sd_sleep: assert property (@(posedge pclk) disable iff (!presetn)
        sleep_mode && power_switch_on == 2'h0 |-> !shutdown_oe_n)
        else $error("shutdown not shown in sleep");
    a_coc_clear: assert property (@(posedge pclk) disable iff (!presetn)
        ce && coc_auto_clr |=> !charge_overcurrent_flag)
        else $error("charge overcurrent flag kept");
    a_wd_restart: assert property (@(posedge pclk) disable iff (!presetn)
        ce && xfer_done |=> sec_cnt == 32'h0 && !timed_out)
        else $error("watchdog not restarted");

    c_timeout: cover property (@(posedge pclk) $rose(timed_out));
    c_resume:  cover property (@(posedge pclk) resume);
    c_pulse:   cover property (@(posedge pclk) $rose(attention_n));
    c_coc:     cover property (@(posedge pclk) coc_auto_clr);
endmodule

// ---- logic/hsfp_defs.svh ----
/*
 * Constants of the host supervision and fault pin block: register
 * offsets, field positions, reset values and timing counts.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef HSFP_DEFS_SVH
`define HSFP_DEFS_SVH

// Register byte offsets on the APB
`define HSFP_OFS_OVERRIDE   8'h00
`define HSFP_OFS_CONFIG     8'h04
`define HSFP_OFS_STATE      8'h08
`define HSFP_OFS_IRQ_STAT   8'h0c
`define HSFP_OFS_IRQ_MASK   8'h10
`define HSFP_OFS_SWITCH     8'h14

// Override register fields
`define HSFP_OVR_SCAN       2
`define HSFP_OVR_CHG_REC    3
`define HSFP_OVR_LOAD_REC   4
`define HSFP_OVR_BALANCE    5
`define HSFP_OVR_POWER      6
`define HSFP_OVR_NV_EN      8
`define HSFP_OVR_RESET      9'h000

// Configuration register fields
`define HSFP_CFG_WD_LSB     3
`define HSFP_CFG_WD_MSB     7
`define HSFP_CFG_CELLF      8
`define HSFP_CFG_OPENW      9
`define HSFP_CFG_RESET      10'h000

// Interrupt event bits
`define HSFP_EV_TIMEOUT     0
`define HSFP_EV_RESUME      1
`define HSFP_EV_FAULT       2
`define HSFP_EV_COC_CLR     3
`define HSFP_EV_WIDTH       4

// Serial address: upper six bits, pin gives the lsb
`define HSFP_ADDR_UPPER     6'h14

// Timing
`define HSFP_CLK_NS         50
`define HSFP_PULSE_NS       1000
`define HSFP_PULSE_CYC ((`HSFP_PULSE_NS + `HSFP_CLK_NS - 1) / `HSFP_CLK_NS)
`define HSFP_SEC_NS         1000000000
`define HSFP_SEC_CYC        (`HSFP_SEC_NS / `HSFP_CLK_NS)

`endif

// ---- logic/hsfp_pkg.sv ----
/*
 * Types of the host supervision and fault pin block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package hsfp_pkg;

    // Watchdog states, one-hot
    typedef enum logic [2:0] {
        HSFP_WD_IDLE  = 3'b001,
        HSFP_WD_WATCH = 3'b010,
        HSFP_WD_ALARM = 3'b100
    } hsfp_wd_state_t;

endpackage

// ---- logic/hsfp_link_mon.sv ----
/*
 * Two-wire serial link monitor: synchronises clock and data pins,
 * finds start and stop, matches the slave address, acknowledges it on
 * the separate data output pin and flags each finished transaction to its own address.
 * Assumes pins are asynchronous to pclk and slow against it.
 */
`timescale 1ns/1ps
`include "hsfp_defs.svh"

module hsfp_link_mon (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    // Pins
    input  wire logic serial_clock_pin,
    input  wire logic serial_data_input_pin,
    input  wire logic addr_lsb,
    output logic      serial_data_output_pin,
    output logic      serial_data_output_oe_n,
    // Event
    output logic      xfer_done
);
    logic [2:0] scl_q;
    logic [2:0] sda_q;
    logic [3:0] bit_cnt;
    logic [7:0] shifter;
    logic       first_byte;
    logic       matched;
    logic       ack_drive;

    wire logic scl_rise  = scl_q[1] & ~scl_q[2];
    wire logic scl_fall  = ~scl_q[1] & scl_q[2];
    wire logic start_seen = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
    wire logic stop_seen  = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
    wire logic addr_hit   = shifter[7:1] == {`HSFP_ADDR_UPPER, addr_lsb};
    wire logic ninth_fall = scl_fall & (bit_cnt == 4'h8);
    wire logic ack_end    = scl_fall & (bit_cnt == 4'h9);

    // Two flops per pin, third stage only feeds the edge logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
        end else if (ce) begin
            scl_q <= {scl_q[1:0], serial_clock_pin};
            sda_q <= {sda_q[1:0], serial_data_input_pin};
        end
    end

    // Bit counting and address capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt    <= 4'h0;
            shifter    <= 8'h00;
            first_byte <= 1'b0;
            matched    <= 1'b0;
        end else if (ce) begin
            if (start_seen) begin
                bit_cnt    <= 4'h0;
                first_byte <= 1'b1;
                matched    <= 1'b0;
            end else if (stop_seen) begin
                matched    <= 1'b0;
                first_byte <= 1'b0;
            end else if (scl_rise) begin
                bit_cnt <= (bit_cnt == 4'h8) ? 4'h9 : bit_cnt + 4'h1;
                if (bit_cnt < 4'h8)
                    shifter <= {shifter[6:0], sda_q[1]};
            end else if (ack_end) begin
                bit_cnt    <= 4'h0;
                first_byte <= 1'b0;
            end else if (ninth_fall && first_byte) begin
                matched <= addr_hit;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ack_drive <= 1'b0;
        else if (ce)
            ack_drive <= (ninth_fall & first_byte & addr_hit) |
                         (ack_drive & ~ack_end & ~stop_seen);
    end

    // Pull low only, the pin pair forms one shared line outside
    assign serial_data_output_pin  = 1'b0;
    assign serial_data_output_oe_n = ~ack_drive;
    assign xfer_done = ce & stop_seen & matched;

    a_ack_addr: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(ack_drive) |-> $past(addr_hit))
        else $error("ack given to a foreign address");
endmodule

// ---- dv/hsfp_host_model.sv ----
/* Serial master model of the host microcontroller.
   Assumes a wired data line with a pull-up, formed by the bench. */
`timescale 1ns/1ps
module hsfp_host_model (
    // Wired data line level
    input  wire logic sda,
    // Pins driven by the host
    output logic      serial_clock_pin,
    output logic      sda_drv_n
);
    // Idle lines released, clock stands high
    initial begin
        serial_clock_pin = 1'h1;
        sda_drv_n        = 1'h1;
    end

    // Start, one byte MSB first, ack, stop
    task automatic xfer(input logic [7:0] b, output logic ack);
        sda_drv_n = 1'h0;
        #200 serial_clock_pin = 1'h0;
        for (int i = 7; i >= 0; i--) begin
            sda_drv_n = b[i];
            #200 serial_clock_pin = 1'h1;
            #200 serial_clock_pin = 1'h0;
        end
        sda_drv_n = 1'h1; // Let the slave pull low
        #200 serial_clock_pin = 1'h1;
        #100 ack = ~sda;
        #100 serial_clock_pin = 1'h0;
        sda_drv_n = 1'h0;
        #200 serial_clock_pin = 1'h1;
        #200 sda_drv_n = 1'h1;
    endtask
endmodule

// ---- dv/tb_hsfp_core.sv ----
/* Bench of the supervision block: APB, link, faults, watchdog.
   Assumes the host model file compiled before it. */
`timescale 1ns/1ps
module tb_hsfp_core;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        force_switches_off_in = 0, address_select_pin, e, ack;
    logic [7:0]  paddr = 0, balance_gate_output;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [11:0] flt = 0;
    logic [1:0]  power_switch_on;
    logic        chg = 0;
    logic        pready, pslverr, serial_data_output_pin, attention_n, irq;
    logic        serial_data_output_oe_n, pack_fault_out, shutdown_oe_n;
    logic        shutdown_indicator_n, charge_complete_n, scan_enable;
    logic        charge_complete_oe_n, wake_request, charge_overcurrent_flag;
    wire         serial_clock_pin, sda_drv_n, serial_data_input_pin;
    int          bad_count = 0, checks = 0, n, m;

    // Both data pins joined on one pulled-up line
    assign serial_data_input_pin = sda_drv_n &
        (serial_data_output_oe_n | serial_data_output_pin);
    always #25 pclk = ~pclk;

    // Short second keeps the run brief
    hsfp_core #(.SEC_CYCLES(200)) hsfp_core_i (.*, .ce(1'h1),
        .charger_monitor_in(chg), .cell_overvoltage_lockout(flt[11]),
        .cell_fail(flt[10]), .open_wire_fail(flt[9]),
        .cell_undervoltage(flt[8]), .discharge_overcurrent(flt[7]),
        .discharge_short_circuit(flt[6]), .discharge_overheat(flt[5]),
        .discharge_too_cold(flt[4]), .die_overheat(flt[3]),
        .charge_overcurrent(flt[2]), .charge_complete_threshold(flt[1]),
        .sleep_mode(flt[0]));
    hsfp_host_model hsfp_host_model_i (.sda(serial_data_input_pin),
        .serial_clock_pin(serial_clock_pin), .sda_drv_n(sda_drv_n));

    task automatic chk(input logic [32:0] g, input logic [32:0] x);
        checks++;
        if (g !== x) begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, g, x);
        end
    endtask

    // One APB transfer; released only after pready is seen
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask

    task automatic final_report;
        if (bad_count == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        address_select_pin = 1'($urandom(32'hb73b));
        repeat (2) @(posedge pclk);
        presetn <= 1;
        repeat (3) @(posedge pclk);
        apb(0, 8'h1c, 0);
        chk({rd, e}, 33'h1);
        for (int i = 0; i < 2; i++) begin
            hsfp_host_model_i.xfer({6'h14, address_select_pin ^ i[0],
                                    1'h0}, ack);
            chk(ack, !i);
        end
        apb(1, 8'h04, 32'h100);
        repeat (30) begin
            flt <= 12'($urandom) & 12'hffb;
            @(negedge pclk);
            chk(pack_fault_out, flt[11] | flt[10]);
            chk({shutdown_oe_n, charge_complete_oe_n},
                {~(|flt[8:3] | flt[0]), ~flt[1]});
            @(posedge pclk);
        end
        flt <= 0;
        chk({shutdown_indicator_n, charge_complete_n}, 0);
        apb(1, 8'h04, 32'h108);
        apb(1, 8'h14, 32'h3ff);
        apb(1, 8'h10, 32'h1);
        apb(1, 8'h00, 32'h164);
        force_switches_off_in <= 1;
        repeat (4) @(negedge pclk);
        chk({balance_gate_output, power_switch_on}, 0);
        @(posedge pclk) force_switches_off_in <= 1'h0;
        repeat (4) @(negedge pclk);
        chk({balance_gate_output, power_switch_on}, 10'h3ff);
        for (n = 0; attention_n !== 1'h0 && n < 400; n++) @(negedge pclk);
        chk(n > 150 && n < 250, 1);
        for (m = 0; attention_n === 1'h0 && m < 99; m++) @(negedge pclk);
        chk(m, 20); // 1 us of 50 ns cycles
        chk({irq, balance_gate_output, power_switch_on}, 11'h400);
        for (n = 0; attention_n !== 1'h0 && n < 400; n++) @(negedge pclk);
        chk(n > 170 && n < 190, 1);
        hsfp_host_model_i.xfer({6'h14, address_select_pin, 1'h0}, ack);
        repeat (10) @(posedge pclk);
        apb(0, 8'h00, 0);
        chk({rd, attention_n}, 33'h41);
        apb(0, 8'h0c, 0);
        chk(rd, 32'h7);
        apb(1, 8'h0c, 32'h7);
        chk(irq, 0);
        // Charger present holds the flag, its removal clears it
        chg <= 1'h1;
        flt <= 12'h005;
        repeat (4) @(negedge pclk);
        chk({charge_overcurrent_flag, wake_request, power_switch_on,
             scan_enable}, 5'h19);
        @(posedge pclk) flt <= 12'h000;
        repeat (4) @(negedge pclk);
        chk(charge_overcurrent_flag, 1);
        @(posedge pclk) chg <= 1'h0;
        repeat (4) @(negedge pclk);
        chk(charge_overcurrent_flag, 0);
        @(posedge pclk);
        apb(0, 8'h0c, 0);
        chk(rd, 32'h8);
        final_report;
    end

    // Hang guard far beyond the expected run
    initial begin
        #2000000;
        bad_count++;
        final_report;
    end
endmodule
